// file: design/cabu_defs.vh
// Constants of the execution unit: opcodes, flag positions, register map, cycle counts
`ifndef CABU_DEFS_VH
`define CABU_DEFS_VH
// Operation codes presented on exec_op
`define CABU_OP_ADD 6'h00
`define CABU_OP_ADD_CARRY 6'h01
`define CABU_OP_SUB 6'h02
`define CABU_OP_SUBTRACT_IMM 6'h03
`define CABU_OP_SUBTRACT_CARRY 6'h04
`define CABU_OP_SUBTRACT_IMM_CARRY 6'h05
`define CABU_OP_AND 6'h06
`define CABU_OP_AND_IMM 6'h07
`define CABU_OP_OR 6'h08
`define CABU_OP_OR_IMM 6'h09
`define CABU_OP_XOR 6'h0A
`define CABU_OP_TEST_ZERO_MINUS 6'h0B
`define CABU_OP_SET_BITS 6'h0C
`define CABU_OP_CLEAR_BITS 6'h0D
`define CABU_OP_WORD_ADD_IMM 6'h0E
`define CABU_OP_WORD_SUB_IMM 6'h0F
`define CABU_OP_JUMP_INDIRECT 6'h10
`define CABU_OP_CALL_INDIRECT 6'h11
`define CABU_OP_RETURN 6'h12
`define CABU_OP_RETURN_IRQ 6'h13
`define CABU_OP_COMPARE_SKIP_EQUAL 6'h14
`define CABU_OP_SKIP_REG_BIT_CLEAR 6'h15
`define CABU_OP_SKIP_REG_BIT_SET 6'h16
`define CABU_OP_SKIP_IO_BIT_CLEAR 6'h17
`define CABU_OP_SKIP_IO_BIT_SET 6'h18
`define CABU_OP_SET_IO_BIT 6'h19
`define CABU_OP_CLEAR_IO_BIT 6'h1A
`define CABU_OP_BRANCH_FLAG_SET 6'h1B
`define CABU_OP_BRANCH_FLAG_CLEAR 6'h1C
`define CABU_OP_BRANCH_SIGNED_GE 6'h1D
`define CABU_OP_BRANCH_SIGNED_LT 6'h1E
`define CABU_OP_BRANCH_UNSIGNED_GE 6'h1F
`define CABU_OP_BRANCH_UNSIGNED_LT 6'h20
`define CABU_OP_BRANCH_IRQ_ON 6'h21
`define CABU_OP_BRANCH_IRQ_OFF 6'h22
// Fixed-flag branches 0x23..0x2E: pairs V,H,T,Z,C,N; odd code = taken on 1
`define CABU_OP_BRANCH_FIXED_FIRST 6'h23
`define CABU_OP_BRANCH_FIXED_LAST 6'h2E
// Status flag bit positions
`define CABU_FLAG_C 0
`define CABU_FLAG_Z 1
`define CABU_FLAG_N 2
`define CABU_FLAG_V 3
`define CABU_FLAG_S 4
`define CABU_FLAG_H 5
`define CABU_FLAG_T 6
`define CABU_FLAG_I 7
`define CABU_FLAGS_RESET 8'h00
// Register indices; byte address is four times the index
`define CABU_IDX_STATUS_FLAGS 8'h5F
`define CABU_IDX_PROG_COUNTER 8'h60
`define CABU_IDX_EXEC_STATE 8'h61
// Serial-port window that refuses single-bit I/O writes
`define CABU_IO_SERIAL_FIRST 6'h08
`define CABU_IO_SERIAL_LAST 6'h0E
// Cycle counts
`define CABU_CYC_ONE 3'h1
`define CABU_CYC_TWO 3'h2
`define CABU_CYC_CALL 3'h3
`define CABU_CYC_RETURN 3'h6
`endif

// file: design/cabu_core.v
// Execution unit of a small 8-bit core: ALU, flags, program counter, Wishbone registers
// Notes on behaviour
// - Add, subtract, subtract-with-carry, reg or immediate, one cycle, set Z C N V S H.
// - AND, OR, XOR in one cycle set Z N V S; carry, half-carry untouched.
// - Test ANDs register with itself, value unchanged, sets Z N V S.
// - Clear-bits ANDs with inverted mask, set-bits ORs mask; both set Z N V S.
// - Word-immediate add and subtract are unsupported on this core.
// - Indirect jump loads PC low 16 bits from Z, upper zero, two cycles.
// - Indirect call pushes return address, loads PC from Z, three cycles.
// - Compare-skip skips next instruction when equal, PC plus 2 or 3, 1/2 cycles.
// - Register bit skips test one bit, skip on clear or set, 1/2 cycles.
// - I/O bit skips test one bit of an I/O register, 1/2 cycles.
// - Single-bit I/O writes never touch serial-port registers 0x08 to 0x0E.
// - Generic branches test a chosen flag, taken loads PC+k+1, 1/2 cycles.
// - Signed GE taken when N xor V is 0, LT when it is 1.
// - Unsigned same-or-higher taken on carry 0, lower on carry 1.
// - Interrupt-state branches taken on I flag 1 or 0, target PC+k+1.
// - Dedicated branches on V H T Z C N, each on flag set or clear.
//
// The implementer's own choice: register access over Wishbone.
`include "cabu_defs.vh"

module cabu_core #(
  parameter PC_W = 22
)(
  input wire clk_sys,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire exec_valid,
  output wire exec_ready,
  input wire [5:0] exec_op,
  input wire [3:0] exec_dst,
  input wire [7:0] exec_rd,
  input wire [7:0] exec_rr,
  input wire [7:0] exec_imm,
  input wire [2:0] exec_bit,
  input wire [6:0] exec_offset,
  input wire [5:0] exec_io_addr,
  input wire exec_next_two_word,
  input wire [15:0] z_ptr,
  input wire [7:0] io_rdata,
  input wire [PC_W-1:0] stack_pop_pc,
  output reg [7:0] res_data_q,
  output reg [3:0] res_dst_q,
  output reg res_we_q,
  output reg io_we_q,
  output reg [5:0] io_addr_q,
  output reg [7:0] io_wdata_q,
  output reg push_we_q,
  output reg [PC_W-1:0] push_pc_q,
  output reg pop_re_q,
  output reg done_q,
  output reg illegal_q,
  output reg [PC_W-1:0] pc_q,
  output reg [7:0] status_flags_q
);

  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;
  reg busy_q;
  reg [2:0] cnt_q;
  reg ack_q;
  reg [2:0] last_cyc_q;

  // Reset release through two flops so every register leaves reset on one edge
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  wire fire = exec_valid & ~busy_q;
  assign exec_ready = ~busy_q;

  // Operand select: immediate forms take exec_imm in place of the second register
  wire use_imm = (exec_op == `CABU_OP_SUBTRACT_IMM) || (exec_op == `CABU_OP_SUBTRACT_IMM_CARRY)
    || (exec_op == `CABU_OP_AND_IMM) || (exec_op == `CABU_OP_OR_IMM)
    || (exec_op == `CABU_OP_SET_BITS) || (exec_op == `CABU_OP_CLEAR_BITS);
  wire [7:0] opb = use_imm ? exec_imm : exec_rr;
  wire cin_add = (exec_op == `CABU_OP_ADD_CARRY) & status_flags_q[`CABU_FLAG_C];
  wire cin_sub = ((exec_op == `CABU_OP_SUBTRACT_CARRY) || (exec_op == `CABU_OP_SUBTRACT_IMM_CARRY))
    & status_flags_q[`CABU_FLAG_C];
  wire [8:0] sum9 = {1'b0, exec_rd} + {1'b0, opb} + {8'h00, cin_add};
  wire [4:0] hsum5 = {1'b0, exec_rd[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin_add};
  wire [8:0] dif9 = {1'b0, exec_rd} - {1'b0, opb} - {8'h00, cin_sub};
  wire [4:0] hdif5 = {1'b0, exec_rd[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin_sub};
  wire [PC_W-1:0] pc_inc = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pc_rel = pc_inc + {{(PC_W-7){exec_offset[6]}}, exec_offset};
  wire [PC_W-1:0] pc_skip = pc_q + (exec_next_two_word ? {{(PC_W-2){1'b0}}, 2'h3}
    : {{(PC_W-2){1'b0}}, 2'h2});
  wire io_serial = (exec_io_addr >= `CABU_IO_SERIAL_FIRST) &&
    (exec_io_addr <= `CABU_IO_SERIAL_LAST);

  // Flag index for the dedicated branches, in pairs V,H,T,Z,C,N
  function [2:0] fixed_flag;
    input [5:0] op;
    begin
      case (op)
        6'h23, 6'h24: fixed_flag = `CABU_FLAG_V;
        6'h25, 6'h26: fixed_flag = `CABU_FLAG_H;
        6'h27, 6'h28: fixed_flag = `CABU_FLAG_T;
        6'h29, 6'h2A: fixed_flag = `CABU_FLAG_Z;
        6'h2B, 6'h2C: fixed_flag = `CABU_FLAG_C;
        default: fixed_flag = `CABU_FLAG_N;
      endcase
    end
  endfunction

  reg [7:0] alu_r;
  reg alu_we;
  reg arith;
  reg logic_op;
  reg sub_op;
  reg [7:0] fl_d;
  reg [PC_W-1:0] pc_d;
  reg [2:0] cyc_d;
  reg io_we_d;
  reg [7:0] io_wdata_d;
  reg push_d;
  reg pop_d;
  reg illegal_d;
  reg take;
  reg [2:0] fsel;

  // Decode and execute; everything is resolved in the cycle an operation is taken
  always @*
  begin
    alu_r = 8'h00;
    alu_we = 1'b0;
    arith = 1'b0;
    logic_op = 1'b0;
    sub_op = 1'b0;
    fl_d = status_flags_q;
    pc_d = pc_inc;
    cyc_d = `CABU_CYC_ONE;
    io_we_d = 1'b0;
    io_wdata_d = io_rdata;
    push_d = 1'b0;
    pop_d = 1'b0;
    illegal_d = 1'b0;
    take = 1'b0;
    fsel = fixed_flag(exec_op);
    case (exec_op)
      `CABU_OP_ADD, `CABU_OP_ADD_CARRY:
      begin
        arith = 1'b1;
        alu_r = sum9[7:0];
      end
      `CABU_OP_SUB, `CABU_OP_SUBTRACT_IMM, `CABU_OP_SUBTRACT_CARRY,
      `CABU_OP_SUBTRACT_IMM_CARRY:
      begin
        arith = 1'b1;
        sub_op = 1'b1;
        alu_r = dif9[7:0];
      end
      `CABU_OP_AND, `CABU_OP_AND_IMM:
      begin
        logic_op = 1'b1;
        alu_r = exec_rd & opb;
      end
      `CABU_OP_OR, `CABU_OP_OR_IMM, `CABU_OP_SET_BITS:
      begin
        logic_op = 1'b1;
        alu_r = exec_rd | opb;
      end
      `CABU_OP_XOR:
      begin
        logic_op = 1'b1;
        alu_r = exec_rd ^ exec_rr;
      end
      `CABU_OP_TEST_ZERO_MINUS:
      begin
        logic_op = 1'b1;
        alu_r = exec_rd & exec_rd;
      end
      `CABU_OP_CLEAR_BITS:
      begin
        logic_op = 1'b1;
        alu_r = exec_rd & (8'hFF - exec_imm);
      end
      `CABU_OP_WORD_ADD_IMM, `CABU_OP_WORD_SUB_IMM:
        illegal_d = 1'b1;
      `CABU_OP_JUMP_INDIRECT:
      begin
        pc_d = {{(PC_W-16){1'b0}}, z_ptr};
        cyc_d = `CABU_CYC_TWO;
      end
      `CABU_OP_CALL_INDIRECT:
      begin
        push_d = 1'b1;
        pc_d = {{(PC_W-16){1'b0}}, z_ptr};
        cyc_d = `CABU_CYC_CALL;
      end
      `CABU_OP_RETURN, `CABU_OP_RETURN_IRQ:
      begin
        pop_d = 1'b1;
        pc_d = stack_pop_pc;
        cyc_d = `CABU_CYC_RETURN;
        if (exec_op == `CABU_OP_RETURN_IRQ)
          fl_d[`CABU_FLAG_I] = 1'b1;
      end
      `CABU_OP_COMPARE_SKIP_EQUAL:
        take = (exec_rd == exec_rr);
      `CABU_OP_SKIP_REG_BIT_CLEAR:
        take = ~exec_rd[exec_bit];
      `CABU_OP_SKIP_REG_BIT_SET:
        take = exec_rd[exec_bit];
      `CABU_OP_SKIP_IO_BIT_CLEAR:
        take = ~io_rdata[exec_bit];
      `CABU_OP_SKIP_IO_BIT_SET:
        take = io_rdata[exec_bit];
      `CABU_OP_SET_IO_BIT, `CABU_OP_CLEAR_IO_BIT:
      begin
        // Read-modify-write of one bit; serial registers would lose pending data
        io_we_d = ~io_serial;
        io_wdata_d[exec_bit] = (exec_op == `CABU_OP_SET_IO_BIT);
      end
      `CABU_OP_BRANCH_FLAG_SET:
        take = status_flags_q[exec_bit];
      `CABU_OP_BRANCH_FLAG_CLEAR:
        take = ~status_flags_q[exec_bit];
      `CABU_OP_BRANCH_SIGNED_GE:
        take = ~(status_flags_q[`CABU_FLAG_N] ^ status_flags_q[`CABU_FLAG_V]);
      `CABU_OP_BRANCH_SIGNED_LT:
        take = status_flags_q[`CABU_FLAG_N] ^ status_flags_q[`CABU_FLAG_V];
      `CABU_OP_BRANCH_UNSIGNED_GE:
        take = ~status_flags_q[`CABU_FLAG_C];
      `CABU_OP_BRANCH_UNSIGNED_LT:
        take = status_flags_q[`CABU_FLAG_C];
      `CABU_OP_BRANCH_IRQ_ON:
        take = status_flags_q[`CABU_FLAG_I];
      `CABU_OP_BRANCH_IRQ_OFF:
        take = ~status_flags_q[`CABU_FLAG_I];
      default:
      begin
        if ((exec_op >= `CABU_OP_BRANCH_FIXED_FIRST) && (exec_op <= `CABU_OP_BRANCH_FIXED_LAST))
          take = ~(status_flags_q[fsel] ^ exec_op[0]);
        else
          illegal_d = 1'b1;
      end
    endcase
    // Skips and branches: two cycles only when taken
    if (take)
    begin
      cyc_d = `CABU_CYC_TWO;
      if (exec_op <= `CABU_OP_SKIP_IO_BIT_SET)
        pc_d = pc_skip;
      else
        pc_d = pc_rel;
    end
    // Arithmetic flags; untouched flags keep their value
    if (arith)
    begin
      alu_we = 1'b1;
      fl_d[`CABU_FLAG_N] = alu_r[7];
      if (sub_op)
      begin
        fl_d[`CABU_FLAG_C] = dif9[8];
        fl_d[`CABU_FLAG_H] = hdif5[4];
        fl_d[`CABU_FLAG_V] = (exec_rd[7] & ~opb[7] & ~alu_r[7]) | (~exec_rd[7] & opb[7] & alu_r[7]);
        // Carry forms chain Z across bytes so multi-byte compares see the whole word
        fl_d[`CABU_FLAG_Z] = (alu_r == 8'h00) & (~(exec_op == `CABU_OP_SUBTRACT_CARRY
          || exec_op == `CABU_OP_SUBTRACT_IMM_CARRY) | status_flags_q[`CABU_FLAG_Z]);
      end
      else
      begin
        fl_d[`CABU_FLAG_C] = sum9[8];
        fl_d[`CABU_FLAG_H] = hsum5[4];
        fl_d[`CABU_FLAG_V] = (exec_rd[7] & opb[7] & ~alu_r[7]) | (~exec_rd[7] & ~opb[7] & alu_r[7]);
        fl_d[`CABU_FLAG_Z] = (alu_r == 8'h00);
      end
      fl_d[`CABU_FLAG_S] = fl_d[`CABU_FLAG_N] ^ fl_d[`CABU_FLAG_V];
    end
    // Logic flags: V cleared, carry and half-carry left alone
    if (logic_op)
    begin
      alu_we = ~(exec_op == `CABU_OP_TEST_ZERO_MINUS);
      fl_d[`CABU_FLAG_Z] = (alu_r == 8'h00);
      fl_d[`CABU_FLAG_N] = alu_r[7];
      fl_d[`CABU_FLAG_V] = 1'b0;
      fl_d[`CABU_FLAG_S] = alu_r[7];
    end
  end

  // Register bus decode; a request counts only while ack is low, so one access acts once
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0] bus_idx = wb_adr_i[9:2];

  // Execution state: results, side effects and the multi-cycle hold
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      res_data_q <= 8'h00;
      res_dst_q <= 4'h0;
      res_we_q <= 1'b0;
      io_we_q <= 1'b0;
      io_addr_q <= 6'h00;
      io_wdata_q <= 8'h00;
      push_we_q <= 1'b0;
      push_pc_q <= {PC_W{1'b0}};
      pop_re_q <= 1'b0;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      pc_q <= {PC_W{1'b0}};
      last_cyc_q <= 3'h0;
    end
    else
    begin
      res_we_q <= fire & alu_we;
      io_we_q <= fire & io_we_d;
      push_we_q <= fire & push_d;
      pop_re_q <= fire & pop_d;
      illegal_q <= fire & illegal_d;
      done_q <= (fire & (cyc_d == `CABU_CYC_ONE)) | (busy_q & (cnt_q == 3'h1));
      if (fire)
      begin
        res_data_q <= alu_r;
        res_dst_q <= exec_dst;
        io_addr_q <= exec_io_addr;
        io_wdata_q <= io_wdata_d;
        push_pc_q <= pc_inc;
        pc_q <= pc_d;
        last_cyc_q <= cyc_d;
        busy_q <= (cyc_d != `CABU_CYC_ONE);
        cnt_q <= cyc_d - 3'h1;
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 3'h1;
        busy_q <= (cnt_q != 3'h1);
      end
    end
  end

  // Flags: an executing operation wins over a bus write in the same cycle
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      status_flags_q <= `CABU_FLAGS_RESET;
    else if (fire)
      status_flags_q <= fl_d;
    else if (bus_wr && (bus_idx == `CABU_IDX_STATUS_FLAGS))
      status_flags_q <= wb_dat_i[7:0];
  end

  // Wishbone classic slave: one wait state, ack dropped after one cycle
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req;
  end
  assign wb_ack_o = ack_q;

  // Read data; unmapped addresses read zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h00000000;
    else if (bus_idx == `CABU_IDX_STATUS_FLAGS)
      wb_dat_o <= {24'h000000, status_flags_q};
    else if (bus_idx == `CABU_IDX_PROG_COUNTER)
      wb_dat_o <= {{(32-PC_W){1'b0}}, pc_q};
    else if (bus_idx == `CABU_IDX_EXEC_STATE)
      wb_dat_o <= {24'h000000, 4'h0, busy_q, last_cyc_q};
    else
      wb_dat_o <= 32'h00000000;
  end

endmodule

// file: tb/cabu_core_assertions.sv
// Concurrent checks on the ports of the execution unit
`include "cabu_defs.vh"
module cabu_core_checker #(
  parameter PC_W = 22
)(
  input wire clk_sys,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire exec_valid,
  input wire exec_ready,
  input wire [5:0] exec_op,
  input wire [15:0] z_ptr,
  input wire res_we_q,
  input wire io_we_q,
  input wire [5:0] io_addr_q,
  input wire push_we_q,
  input wire pop_re_q,
  input wire done_q,
  input wire illegal_q,
  input wire [PC_W-1:0] pc_q,
  input wire [7:0] status_flags_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Operation accepted at this edge, and the logic group that keeps carry and half-carry
  wire tk = exec_valid && exec_ready;
  wire lg = exec_op == `CABU_OP_AND || exec_op == `CABU_OP_AND_IMM || exec_op == `CABU_OP_OR
    || exec_op == `CABU_OP_OR_IMM || exec_op == `CABU_OP_XOR;
  wire rt = exec_op == `CABU_OP_RETURN || exec_op == `CABU_OP_RETURN_IRQ;
  a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged in the next cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_alu_single_cycle: assert property (tk && exec_op == `CABU_OP_ADD |=> res_we_q && done_q && exec_ready)
    else $error("add did not finish in one cycle");
  a_logic_keeps_carry: assert property (tk && lg |=> (status_flags_q & 8'h21) == ($past(status_flags_q) & 8'h21))
    else $error("logic operation changed carry or half-carry");
  a_word_op_refused: assert property (tk && (exec_op == `CABU_OP_WORD_ADD_IMM || exec_op == `CABU_OP_WORD_SUB_IMM)
    |=> illegal_q && !res_we_q && done_q)
    else $error("word immediate operation was not refused");
  a_jump_two_cycles: assert property (tk && exec_op == `CABU_OP_JUMP_INDIRECT |=> pc_q == {{(PC_W-16){1'b0}}, $past(z_ptr)}
    && !exec_ready ##1 done_q && exec_ready)
    else $error("indirect jump target or length wrong");
  a_call_three_cycles: assert property (tk && exec_op == `CABU_OP_CALL_INDIRECT |=> push_we_q && !exec_ready
    ##1 !exec_ready && !done_q ##1 done_q)
    else $error("indirect call push or length wrong");
  a_return_six_cycles: assert property (tk && rt |=> pop_re_q ##0 (!exec_ready && !done_q)[*5] ##1 done_q)
    else $error("return did not take six cycles");
  a_op_return_irq_sets_irq: assert property (tk && exec_op == `CABU_OP_RETURN_IRQ |=> status_flags_q[7])
    else $error("interrupt return left interrupts disabled");
  a_serial_no_bit: assert property (io_we_q |-> io_addr_q < `CABU_IO_SERIAL_FIRST || io_addr_q > `CABU_IO_SERIAL_LAST)
    else $error("single-bit write reached a serial-port register");
  c_call: cover property (tk && exec_op == `CABU_OP_CALL_INDIRECT);
  c_op_return_irq: cover property (tk && exec_op == `CABU_OP_RETURN_IRQ);
  c_bus: cover property (wb_ack_o);
endmodule

// file: tb/cabu_core_test.sv
// Self-checking bench of the execution unit
`include "cabu_defs.vh"
module cabu_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, exec_valid, exec_ready, exec_next_two_word;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i, exec_dst, res_dst_q;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [5:0] exec_op, exec_io_addr, io_addr_q;
  logic [7:0] exec_rd, exec_rr, exec_imm, io_rdata, res_data_q, io_wdata_q, status_flags_q;
  logic [2:0] exec_bit;
  logic [6:0] exec_offset;
  logic [15:0] z_ptr;
  logic [21:0] stack_pop_pc, push_pc_q, pc_q, exp_pc;
  logic res_we_q, io_we_q, push_we_q, pop_re_q, done_q, illegal_q;
  logic [4:0] snap;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  cabu_core i_cabu_core (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exec_valid(exec_valid), .exec_ready(exec_ready),
    .exec_op(exec_op), .exec_dst(exec_dst), .exec_rd(exec_rd), .exec_rr(exec_rr),
    .exec_imm(exec_imm), .exec_bit(exec_bit), .exec_offset(exec_offset),
    .exec_io_addr(exec_io_addr), .exec_next_two_word(exec_next_two_word), .z_ptr(z_ptr),
    .io_rdata(io_rdata), .stack_pop_pc(stack_pop_pc), .res_data_q(res_data_q),
    .res_dst_q(res_dst_q), .res_we_q(res_we_q), .io_we_q(io_we_q), .io_addr_q(io_addr_q),
    .io_wdata_q(io_wdata_q), .push_we_q(push_we_q), .push_pc_q(push_pc_q), .pop_re_q(pop_re_q),
    .done_q(done_q), .illegal_q(illegal_q), .pc_q(pc_q), .status_flags_q(status_flags_q));
  // Clock at 25 MHz
  always #20 clk_sys = ~clk_sys;
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard; the whole run needs well under a tenth of this
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single cycle; request held until ack is sampled high
  task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h0, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic setf(input logic [7:0] f);
    bus(1'b1, 10'h17C, f);
  endtask
  // Issue one operation, count cycles to done and keep the first-cycle pulses
  task automatic run(input logic [5:0] op, input int nc, input logic [21:0] npc);
    int n;
    @(posedge clk_sys);
    exec_op <= op;
    exec_valid <= 1'b1;
    @(posedge clk_sys);
    exec_valid <= 1'b0;
    n = 1;
    @(negedge clk_sys);
    snap = {res_we_q, io_we_q, push_we_q, pop_re_q, illegal_q};
    while (done_q !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("cycles", nc, n);
    chk("pc", npc, pc_q);
    exp_pc = npc;
  endtask
  task automatic alu(input logic [5:0] op, input logic [7:0] a, b, f, r, fe);
    setf(f);
    {exec_rd, exec_rr, exec_imm} <= {a, b, b};
    run(op, 1, exp_pc + 1);
    chk("result", r, res_data_q);
    chk("flags", fe, status_flags_q);
  endtask
  task automatic t_regs();
    bus(1'b0, 10'h17C, 8'h00);
    chk("flags reset", 32'h0, q);
    bus(1'b1, 10'h3FC, 8'hFF);
    bus(1'b0, 10'h3FC, 8'h00);
    chk("unmapped", 32'h0, q);
    bus(1'b1, 10'h180, 8'h55);
    bus(1'b0, 10'h180, 8'h00);
    chk("pc read only", 32'h0, q);
    setf(8'hA5);
    bus(1'b0, 10'h17C, 8'h00);
    chk("flags rw", 32'hA5, q);
  endtask
  task automatic t_alu();
    alu(`CABU_OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h2C);
    chk("dst", 32'h5, res_dst_q);
    alu(`CABU_OP_ADD_CARRY, 8'hFF, 8'h00, 8'h41, 8'h00, 8'h63);
    alu(`CABU_OP_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h35);
    alu(`CABU_OP_SUBTRACT_IMM, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h38);
    alu(`CABU_OP_SUBTRACT_CARRY, 8'h05, 8'h04, 8'h03, 8'h00, 8'h02);
    alu(`CABU_OP_SUBTRACT_IMM_CARRY, 8'h05, 8'h04, 8'h01, 8'h00, 8'h00);
    alu(`CABU_OP_AND, 8'hF0, 8'h8F, 8'h21, 8'h80, 8'h35);
    alu(`CABU_OP_AND_IMM, 8'h0F, 8'h3C, 8'h29, 8'h0C, 8'h21);
    alu(`CABU_OP_OR, 8'h00, 8'h00, 8'h29, 8'h00, 8'h23);
    alu(`CABU_OP_OR_IMM, 8'h80, 8'h01, 8'h29, 8'h81, 8'h35);
    alu(`CABU_OP_XOR, 8'h55, 8'h55, 8'h29, 8'h00, 8'h23);
    alu(`CABU_OP_CLEAR_BITS, 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'h14);
    alu(`CABU_OP_SET_BITS, 8'h00, 8'h81, 8'h00, 8'h81, 8'h14);
    setf(8'h08);
    exec_rd <= 8'h80;
    run(`CABU_OP_TEST_ZERO_MINUS, 1, exp_pc + 1);
    chk("test flags", 32'h14, status_flags_q);
    chk("test no write", 32'h0, snap[4]);
    run(`CABU_OP_WORD_ADD_IMM, 1, exp_pc + 1);
    chk("word add refused", 32'h1, snap[0]);
    run(`CABU_OP_WORD_SUB_IMM, 1, exp_pc + 1);
    chk("word sub refused", 32'h1, snap[0]);
    chk("word flags kept", 32'h14, status_flags_q);
  endtask
  task automatic t_flow();
    logic [21:0] ret;
    z_ptr <= 16'hBEEF;
    run(`CABU_OP_JUMP_INDIRECT, 2, 22'h00BEEF);
    ret = exp_pc + 1;
    z_ptr <= 16'h1234;
    run(`CABU_OP_CALL_INDIRECT, 3, 22'h001234);
    chk("push", 32'h1, snap[2]);
    chk("push pc", ret, push_pc_q);
    setf(8'h00);
    stack_pop_pc <= 22'h2ABCDE;
    run(`CABU_OP_RETURN_IRQ, 6, 22'h2ABCDE);
    chk("irq on", 32'h80, status_flags_q);
    stack_pop_pc <= 22'h001555;
    run(`CABU_OP_RETURN, 6, 22'h001555);
    chk("pop", 32'h1, snap[1]);
    bus(1'b0, 10'h180, 8'h00);
    chk("pc reg", 32'h001555, q);
    bus(1'b0, 10'h184, 8'h00);
    chk("exec state", 32'h6, q);
  endtask
  task automatic t_skip_io();
    logic [5:0] al [4] = '{6'h07, 6'h08, 6'h0E, 6'h0F};
    {exec_rd, exec_rr, exec_next_two_word} <= {8'h3C, 8'h3C, 1'b1};
    run(`CABU_OP_COMPARE_SKIP_EQUAL, 2, exp_pc + 3);
    {exec_rr, exec_next_two_word} <= {8'h3D, 1'b0};
    run(`CABU_OP_COMPARE_SKIP_EQUAL, 1, exp_pc + 1);
    {exec_rd, exec_bit} <= {8'hFB, 3'h2};
    run(`CABU_OP_SKIP_REG_BIT_CLEAR, 2, exp_pc + 2);
    run(`CABU_OP_SKIP_REG_BIT_SET, 1, exp_pc + 1);
    {io_rdata, exec_bit} <= {8'h80, 3'h7};
    run(`CABU_OP_SKIP_IO_BIT_SET, 2, exp_pc + 2);
    run(`CABU_OP_SKIP_IO_BIT_CLEAR, 1, exp_pc + 1);
    // Edges of the serial window and one address either side
    foreach (al[i])
    begin
      {exec_io_addr, io_rdata, exec_bit} <= {al[i], 8'h00, 3'h3};
      run(`CABU_OP_SET_IO_BIT, 1, exp_pc + 1);
      chk("bit write", al[i] < 6'h08 || al[i] > 6'h0E, snap[3]);
      if (snap[3])
        chk("set data", 32'h08, io_wdata_q);
    end
    {io_rdata, exec_bit} <= {8'hFF, 3'h0};
    run(`CABU_OP_CLEAR_IO_BIT, 1, exp_pc + 1);
    chk("clear data", 32'hFE, io_wdata_q);
  endtask
  // Branch condition worked out from the flags held before the branch
  function automatic logic taken(input logic [5:0] op, input logic [7:0] f);
    int p [6] = '{3, 5, 6, 1, 0, 2};
    case (op)
      `CABU_OP_BRANCH_FLAG_SET: return f[1];
      `CABU_OP_BRANCH_FLAG_CLEAR: return !f[1];
      `CABU_OP_BRANCH_SIGNED_GE: return !(f[2] ^ f[3]);
      `CABU_OP_BRANCH_SIGNED_LT: return f[2] ^ f[3];
      `CABU_OP_BRANCH_UNSIGNED_GE: return !f[0];
      `CABU_OP_BRANCH_UNSIGNED_LT: return f[0];
      `CABU_OP_BRANCH_IRQ_ON: return f[7];
      `CABU_OP_BRANCH_IRQ_OFF: return !f[7];
      default: return f[p[(op - 6'h23) >> 1]] ^ !op[0];
    endcase
  endfunction
  task automatic t_branch();
    logic [7:0] fl [4] = '{8'h00, 8'hFF, 8'h08, 8'h0C};
    logic t;
    {exec_bit, exec_offset} <= {3'h1, 7'h7E};
    foreach (fl[i])
      for (int o = 'h1B; o <= 'h2E; o++)
      begin
        setf(fl[i]);
        t = taken(o[5:0], fl[i]);
        run(o[5:0], t ? 2 : 1, t ? exp_pc - 1 : exp_pc + 1);
        chk("flags kept", fl[i], status_flags_q);
      end
  endtask
  // Inputs quiet at time zero, reset for 16 cycles, then the scenarios
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, exec_valid, exec_next_two_word} = '0;
    {exec_op, exec_rd, exec_rr, exec_imm, exec_bit, exec_offset, exec_io_addr} = '0;
    {z_ptr, io_rdata, stack_pop_pc, exp_pc} = '0;
    wb_sel_i = 4'h1;
    exec_dst = 4'h5;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_alu();
    t_flow();
    t_skip_io();
    t_branch();
    results();
  end
endmodule
bind cabu_core cabu_core_checker #(.PC_W(PC_W)) i_cabu_core_checker (.clk_sys(clk_sys),
  .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .exec_valid(exec_valid), .exec_ready(exec_ready), .exec_op(exec_op), .z_ptr(z_ptr),
  .res_we_q(res_we_q), .io_we_q(io_we_q), .io_addr_q(io_addr_q), .push_we_q(push_we_q),
  .pop_re_q(pop_re_q), .done_q(done_q), .illegal_q(illegal_q), .pc_q(pc_q),
  .status_flags_q(status_flags_q));
